// ==== rtl/pbc_top.sv ====
// Photon bin counter: shaper, hold-off, bin timer, result buffer and register port
`include "pbc_map.svh"
module pbc_top import pbc_pkg::*; #(
    parameter int DEPTH = 4000,
    parameter int CW = 31,
    parameter logic [31:0] DEF_BIN_CYC = 32'(`PBC_BIN_CYC)
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic DET_IN,
    input wire logic GATE_IN,
    output logic PULSE_OUT,
    output logic APD_EN,
    output logic LED_GREEN,
    output logic IRQ,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [CW-1:0] CNT_MAX = '1;
    localparam logic [3:0] SHAPE_CYC = 4'(`PBC_SHAPE_CYC);

    pbc_buf_if #(.DW(CW), .LW(AW + 1)) rbuf ();

    pbc_mode_e mode_ff;
    pbc_state_e st_ff;
    pbc_state_e nxt_st;
    logic [31:0] bin_len_ff;
    logic [31:0] gap_ff;
    logic [31:0] blind_ff;
    logic [15:0] nbins_ff;
    logic [15:0] bins_ff;
    logic [31:0] tmr_ff;
    logic [31:0] blind_cnt_ff;
    logic [CW-1:0] cnt_ff;
    logic [3:0] shp_cnt_ff;
    logic shp_new_ff;
    logic det_q_ff;
    logic gate_q_ff;
    logic bin_end_ff;
    logic full_q_ff;
    logic ovf_seen_ff;
    logic lost_seen_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic led_ff;
    logic apd_ff;
    logic [31:0] rdata_ff;
    logic gmode;
    logic gate_act;
    logic trig_rise;
    logic counting;
    logic cnt_pulse;
    logic start_cmd;
    logic stop_cmd;
    logic last_bin;
    logic bin_start;
    logic bin_end;
    logic [3:0] ev;

    ////////////////////////////////////////////////////////////////////////////////
    // Input edges and pulse shaper
    assign gmode = mode_ff == PBC_GATE1 || mode_ff == PBC_GATE2;
    // Variant one gates on a low level, variant two on a high level
    assign gate_act = (mode_ff == PBC_GATE1) ? !GATE_IN : GATE_IN;
    assign trig_rise = GATE_IN && !gate_q_ff;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            det_q_ff <= 1'b0;
            gate_q_ff <= 1'b0;
            shp_cnt_ff <= 4'h0;
            shp_new_ff <= 1'b0;
        end else if (CE) begin
            det_q_ff <= DET_IN;
            gate_q_ff <= GATE_IN;
            shp_new_ff <= DET_IN && !det_q_ff;
            if (DET_IN && !det_q_ff) begin
                shp_cnt_ff <= SHAPE_CYC;
            end else if (shp_cnt_ff != 4'h0) begin
                shp_cnt_ff <= shp_cnt_ff - 4'h1;
            end
        end
    end

    assign PULSE_OUT = shp_cnt_ff != 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Hold-off filter and bin counter
    assign counting = st_ff == ST_COUNT && !(gmode && !gate_act);
    assign cnt_pulse = shp_new_ff && counting && blind_cnt_ff == 32'h0;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            blind_cnt_ff <= 32'h0;
        end else if (CE) begin
            if (cnt_pulse) begin
                blind_cnt_ff <= blind_ff;
            end else if (blind_cnt_ff != 32'h0) begin
                blind_cnt_ff <= blind_cnt_ff - 32'h1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            cnt_ff <= '0;
        end else if (CE) begin
            if (bin_start) begin
                cnt_ff <= '0;
            end else if (cnt_pulse && cnt_ff != CNT_MAX) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bin sequencer
    assign start_cmd = WR && ADDR == `PBC_OFF_CMD && WDATA[`PBC_CMD_START] && st_ff == ST_IDLE;
    assign stop_cmd = WR && ADDR == `PBC_OFF_CMD && WDATA[`PBC_CMD_STOP];
    assign last_bin = mode_ff == PBC_MANUAL || (nbins_ff != 16'h0 && bins_ff == nbins_ff - 16'h1);

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_IDLE: begin
                if (start_cmd) begin
                    nxt_st = (mode_ff == PBC_MANUAL || mode_ff == PBC_FREE) ? ST_COUNT : ST_ARM;
                end
            end
            ST_ARM: begin
                if (gmode ? gate_act : trig_rise) begin
                    nxt_st = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (gmode ? !gate_act : tmr_ff == 32'h0) begin
                    nxt_st = last_bin ? ST_IDLE : (mode_ff == PBC_FREE ? ST_GAP : ST_ARM);
                end
            end
            ST_GAP: begin
                if (tmr_ff == 32'h0) begin
                    nxt_st = ST_COUNT;
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
        if (stop_cmd) begin
            nxt_st = ST_IDLE;
        end
    end

    assign bin_start = st_ff != ST_COUNT && nxt_st == ST_COUNT;
    assign bin_end = st_ff == ST_COUNT && nxt_st != ST_COUNT && !stop_cmd;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_ff <= ST_IDLE;
            tmr_ff <= 32'h0;
            bins_ff <= 16'h0;
            bin_end_ff <= 1'b0;
        end else if (CE) begin
            st_ff <= nxt_st;
            bin_end_ff <= bin_end;
            if (bin_start) begin
                tmr_ff <= (bin_len_ff == 32'h0) ? 32'h0 : bin_len_ff - 32'h1;
            end else if (st_ff != ST_GAP && nxt_st == ST_GAP) begin
                tmr_ff <= (gap_ff == 32'h0) ? 32'h0 : gap_ff - 32'h1;
            end else if (tmr_ff != 32'h0) begin
                tmr_ff <= tmr_ff - 32'h1;
            end
            if (start_cmd) begin
                bins_ff <= 16'h0;
            end else if (bin_end) begin
                bins_ff <= bins_ff + 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result buffer
    assign rbuf.push_valid = bin_end_ff;
    assign rbuf.push_data = cnt_ff;
    assign rbuf.pop_ready = RD && ADDR == `PBC_OFF_DATA;

    pbc_buf #(.DW(CW), .DEPTH(DEPTH)) u_buf (
        .clk(CLK),
        .srst(SRST),
        .ce(CE),
        .bus(rbuf)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Status, interrupts and pins
    assign ev[`PBC_IRQ_BIN] = bin_end_ff && rbuf.push_ready;
    assign ev[`PBC_IRQ_OVF] = cnt_pulse && cnt_ff == CNT_MAX;
    assign ev[`PBC_IRQ_LOST] = bin_end_ff && !rbuf.push_ready;
    assign ev[`PBC_IRQ_OVL] = !rbuf.push_ready && !full_q_ff;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_stat_ff <= 4'h0;
            full_q_ff <= 1'b0;
            ovf_seen_ff <= 1'b0;
            lost_seen_ff <= 1'b0;
            led_ff <= 1'b1;
            apd_ff <= 1'b0;
        end else if (CE) begin
            // Set beats a simultaneous write-one-to-clear
            irq_stat_ff <= (irq_stat_ff & ~((WR && ADDR == `PBC_OFF_ISTAT) ? WDATA[3:0] : 4'h0)) | ev;
            full_q_ff <= !rbuf.push_ready;
            ovf_seen_ff <= (ovf_seen_ff && !start_cmd) || ev[`PBC_IRQ_OVF];
            lost_seen_ff <= (lost_seen_ff && !start_cmd) || ev[`PBC_IRQ_LOST];
            led_ff <= nxt_st == ST_IDLE;
            apd_ff <= gmode ? (gate_act && nxt_st != ST_IDLE) : 1'b1;
        end
    end

    assign IRQ = |(irq_stat_ff & irq_mask_ff);
    assign LED_GREEN = led_ff;
    assign APD_EN = apd_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_ff <= pbc_mode_e'(`PBC_MODE_RST);
            bin_len_ff <= DEF_BIN_CYC;
            gap_ff <= 32'(`PBC_GAP_CYC);
            blind_ff <= `PBC_BLIND_RST;
            nbins_ff <= `PBC_NBINS_RST;
            irq_mask_ff <= 4'h0;
        end else if (CE && WR) begin
            unique case (ADDR)
                `PBC_OFF_CTRL: begin
                    if (WDATA[2:0] <= 3'h4) begin
                        mode_ff <= pbc_mode_e'(WDATA[2:0]);
                    end
                end
                `PBC_OFF_BIN: bin_len_ff <= WDATA;
                `PBC_OFF_GAP: gap_ff <= WDATA;
                `PBC_OFF_BLIND: blind_ff <= WDATA;
                `PBC_OFF_NBINS: nbins_ff <= WDATA[15:0];
                `PBC_OFF_IMASK: irq_mask_ff <= WDATA[3:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_ff <= 32'h0;
        end else if (CE) begin
            rdata_ff <= 32'h0;
            if (RD) begin
                unique case (ADDR)
                    `PBC_OFF_CTRL: rdata_ff <= {29'h0, mode_ff};
                    `PBC_OFF_BIN: rdata_ff <= bin_len_ff;
                    `PBC_OFF_GAP: rdata_ff <= gap_ff;
                    `PBC_OFF_BLIND: rdata_ff <= blind_ff;
                    `PBC_OFF_NBINS: rdata_ff <= {16'h0, nbins_ff};
                    `PBC_OFF_STATUS: rdata_ff <= {3'h0, 13'(rbuf.level), 10'h0, lost_seen_ff, ovf_seen_ff,
                        !rbuf.push_ready, !(mode_ff == PBC_MANUAL || mode_ff == PBC_FREE),
                        counting, st_ff != ST_IDLE};
                    `PBC_OFF_DATA: rdata_ff <= rbuf.pop_valid ? {1'b1, rbuf.head} : 32'h0;
                    `PBC_OFF_ISTAT: rdata_ff <= {28'h0, irq_stat_ff};
                    `PBC_OFF_IMASK: rdata_ff <= {28'h0, irq_mask_ff};
                    `PBC_OFF_LIVE: rdata_ff <= {1'b0, cnt_ff};
                    default: rdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign RDATA = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST || !CE);

    sequence s_trig_seen;
        st_ff == ST_ARM && mode_ff == PBC_TRIG && trig_rise && !stop_cmd;
    endsequence
    sequence s_timed_end;
        st_ff == ST_COUNT && !gmode && tmr_ff == 32'h0 && !stop_cmd;
    endsequence

    blind_block_a: assert property ((blind_cnt_ff != 32'h0 && !bin_start) |=> cnt_ff == $past(cnt_ff))
        else $error("pulse counted during hold-off");
    blind_load_a: assert property (cnt_pulse |=> blind_cnt_ff == $past(blind_ff))
        else $error("hold-off not started at counted pulse");
    shape_out_a: assert property ((DET_IN && !det_q_ff) |=> PULSE_OUT && shp_new_ff)
        else $error("detector edge not shaped");
    count_step_a: assert property ((cnt_pulse && !bin_start && cnt_ff != CNT_MAX)
        |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("counter missed a shaped pulse");
    data_read_a: assert property ((RD && ADDR == `PBC_OFF_DATA && rbuf.pop_valid)
        |=> RDATA == {1'b1, $past(rbuf.head)})
        else $error("buffer head not returned");
    timed_end_a: assert property (s_timed_end |=> st_ff != ST_COUNT ##1 bin_end_ff == 1'b0)
        else $error("timed bin overran its length");
    manual_go_a: assert property ((start_cmd && mode_ff == PBC_MANUAL && !stop_cmd) |=> st_ff == ST_COUNT)
        else $error("manual start did not count");
    trig_go_a: assert property (s_trig_seen |=> st_ff == ST_COUNT)
        else $error("trigger edge did not start bin");
    gate_apd_a: assert property ((gmode && st_ff != ST_IDLE && !gate_act && !start_cmd)
        |=> !APD_EN && !counting)
        else $error("inactive gate left detector enabled");
    mode_reset_a: assert property ($past(SRST) |-> mode_ff == PBC_GATE2)
        else $error("reset mode is not gate variant two");
    led_dark_a: assert property (st_ff != ST_IDLE |-> !LED_GREEN)
        else $error("indicator lit during measurement");
    ovf_flag_a: assert property (ev[`PBC_IRQ_OVF] |=> irq_stat_ff[`PBC_IRQ_OVF] && ovf_seen_ff)
        else $error("counter overflow not flagged");
    lost_flag_a: assert property ((bin_end_ff && !rbuf.push_ready) |=> irq_stat_ff[`PBC_IRQ_LOST])
        else $error("lost bin not flagged");
    ovl_flag_a: assert property ($fell(rbuf.push_ready) |-> irq_stat_ff[`PBC_IRQ_OVL] == 1'b0 ##1
        irq_stat_ff[`PBC_IRQ_OVL])
        else $error("overload not raised");
    clear_bin_a: assert property (bin_start |=> cnt_ff == '0)
        else $error("counter not cleared at bin start");
endmodule : pbc_top

// ==== rtl/pbc_map.svh ====
// Offsets, field positions, reset values and timing counts of the photon bin counter
`ifndef PBC_MAP_SVH
`define PBC_MAP_SVH
`define PBC_CLK_NS 100
`define PBC_SHAPE_NS 14
`define PBC_SHAPE_CYC ((`PBC_SHAPE_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_BIN_US 100000
`define PBC_BIN_CYC ((`PBC_BIN_US * 1000 + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_GAP_NS 1000
`define PBC_GAP_CYC ((`PBC_GAP_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_BLIND_RST 32'h00000000
`define PBC_NBINS_RST 16'h0064
`define PBC_MODE_RST 3'h4
`define PBC_OFF_CTRL 8'h00
`define PBC_OFF_CMD 8'h04
`define PBC_OFF_BIN 8'h08
`define PBC_OFF_GAP 8'h0C
`define PBC_OFF_BLIND 8'h10
`define PBC_OFF_NBINS 8'h14
`define PBC_OFF_STATUS 8'h18
`define PBC_OFF_DATA 8'h1C
`define PBC_OFF_ISTAT 8'h20
`define PBC_OFF_IMASK 8'h24
`define PBC_OFF_LIVE 8'h28
`define PBC_CMD_START 0
`define PBC_CMD_STOP 1
`define PBC_IRQ_BIN 0
`define PBC_IRQ_OVF 1
`define PBC_IRQ_LOST 2
`define PBC_IRQ_OVL 3
`endif

// ==== rtl/pbc_pkg.sv ====
// Types of the photon bin counter
package pbc_pkg;
    typedef enum logic [2:0] {
        PBC_MANUAL = 3'h0,
        PBC_FREE = 3'h1,
        PBC_TRIG = 3'h2,
        PBC_GATE1 = 3'h3,
        PBC_GATE2 = 3'h4
    } pbc_mode_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARM = 4'h2,
        ST_COUNT = 4'h4,
        ST_GAP = 4'h8
    } pbc_state_e;
endpackage : pbc_pkg

// ==== rtl/pbc_buf_if.sv ====
// Push and pop signals between counter and result buffer
interface pbc_buf_if #(parameter int DW = 31, parameter int LW = 13);
    logic push_valid;
    logic push_ready;
    logic [DW-1:0] push_data;
    logic pop_ready;
    logic pop_valid;
    logic [DW-1:0] head;
    logic [LW-1:0] level;
    modport src(output push_valid, push_data, pop_ready, input push_ready, pop_valid, head, level);
    modport mem(input push_valid, push_data, pop_ready, output push_ready, pop_valid, head, level);
endinterface : pbc_buf_if

// ==== rtl/pbc_buf.sv ====
// Result buffer with registered head word
module pbc_buf import pbc_pkg::*; #(
    parameter int DW = 31,
    parameter int DEPTH = 4000,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    pbc_buf_if.mem bus
);
    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW-1:0] nxt_rd_ptr;
    logic [AW:0] level_ff;
    logic [DW-1:0] head_ff;
    logic do_push;
    logic do_pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : wrap_inc

    assign bus.push_ready = level_ff != (AW+1)'(DEPTH);
    assign bus.pop_valid = level_ff != '0;
    assign bus.head = head_ff;
    assign bus.level = level_ff;
    assign do_push = bus.push_valid && bus.push_ready;
    assign do_pop = bus.pop_ready && bus.pop_valid;
    assign nxt_rd_ptr = do_pop ? wrap_inc(rd_ptr_ff) : rd_ptr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage
    always_ff @(posedge clk) begin
        if (!srst && ce && do_push) begin
            mem[wr_ptr_ff] <= bus.push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff <= '0;
            head_ff <= '0;
        end else if (ce) begin
            if (do_push) begin
                wr_ptr_ff <= wrap_inc(wr_ptr_ff);
            end
            rd_ptr_ff <= nxt_rd_ptr;
            level_ff <= level_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
            // Bypass keeps the head valid when writing into the slot being read
            head_ff <= (do_push && wr_ptr_ff == nxt_rd_ptr) ? bus.push_data : mem[nxt_rd_ptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    level_bound_a: assert property (@(posedge clk) disable iff (srst) level_ff <= (AW+1)'(DEPTH))
        else $error("buffer level above depth");
    full_refuse_a: assert property (@(posedge clk) disable iff (srst || !ce)
        (!bus.push_ready && !do_pop) |=> level_ff == $past(level_ff))
        else $error("full buffer accepted a push");
endmodule : pbc_buf

// ==== test/pbc_field_model.sv ====
// Detector comparator and gate/trigger source model
module pbc_field_model (
    input wire logic clk,
    output logic det,
    output logic gate
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        det = 1'b0;
        gate = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Detector events, hi cycles high then lo cycles low
    task automatic burst(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            repeat (hi) @(posedge clk) det <= 1'b1;
            repeat (lo) @(posedge clk) det <= 1'b0;
        end
    endtask : burst

    // Gate level or trigger edge
    task automatic set_gate(input logic lvl);
        @(posedge clk) gate <= lvl;
    endtask : set_gate
endmodule : pbc_field_model

// ==== test/photon_bin_counter_tb.sv ====
// Self-checking bench of the photon bin counter
`include "pbc_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module photon_bin_counter_tb import pbc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 8;
    logic clk, srst, ce, det_in, gate_in, pulse_out, apd_en, led_green, irq, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, v;
    int miscompares = 0, n_checks = 0, n_pulse = 0, cyc = 0;

    pbc_top #(.DEPTH(DEPTH), .DEF_BIN_CYC(32'h00000014)) DUT (.CLK(clk), .SRST(srst), .CE(ce), .DET_IN(det_in),
        .GATE_IN(gate_in), .PULSE_OUT(pulse_out), .APD_EN(apd_en), .LED_GREEN(led_green), .IRQ(irq),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    pbc_field_model fld (.clk(clk), .det(det_in), .gate(gate_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Shaped pulse cycles and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pulse_out === 1'b1) n_pulse <= n_pulse + 1;
        if (cyc == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rd_reg(`PBC_OFF_STATUS, v);
            if (v[0] === 1'b0) break;
        end
        `CHK("running", 1'b0, v[0])
        repeat (4) @(posedge clk);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        `CHK("led_idle", 1'b1, led_green)
        rd_reg(`PBC_OFF_CTRL, v);
        `CHK("mode_rst", 3'h4, v[2:0])
        `CHK("apd_idle", 1'b0, apd_en)
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("trig_en", 1'b1, v[2])
        rd_reg(`PBC_OFF_GAP, v);
        `CHK("gap_rst", 32'(`PBC_GAP_CYC), v)
        rd_reg(`PBC_OFF_NBINS, v);
        `CHK("nbins_rst", 32'(`PBC_NBINS_RST), v)
        rd_reg(`PBC_OFF_BLIND, v);
        `CHK("blind_rst", `PBC_BLIND_RST, v)
        rd_reg(8'hF0, v);
        `CHK("unmapped", 32'h00000000, v)
    endtask : t_reset

    task automatic run_manual(input int blind, input int n, input int hi, input int lo, input int exp);
        int p0;
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_MANUAL));
        wr_reg(`PBC_OFF_BIN, 32'h0000003C);
        wr_reg(`PBC_OFF_BLIND, 32'(blind));
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        p0 = n_pulse;
        fld.burst(n, hi, lo);
        `CHK("led_run", 1'b0, led_green)
        wait_idle();
        `CHK("pulses", n, n_pulse - p0)
        rd_reg(`PBC_OFF_DATA, v);
        `CHK("bin", 32'h80000000 | 32'(exp), v)
    endtask : run_manual

    task automatic t_manual();
        run_manual(0, 3, 1, 2, 3);
        run_manual(5, 6, 1, 3, 3);
        run_manual(3, 6, 5, 1, 6);
    endtask : t_manual

    task automatic t_free();
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_FREE));
        wr_reg(`PBC_OFF_BIN, 32'h00000014);
        wr_reg(`PBC_OFF_GAP, 32'h0000000A);
        wr_reg(`PBC_OFF_NBINS, 32'h00000003);
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        repeat (35) @(posedge clk);
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("lvl_gap", 13'h0001, v[28:16])
        `CHK("trig_dis", 1'b0, v[2])
        wait_idle();
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("lvl_end", 13'h0003, v[28:16])
        for (int i = 0; i < 3; i++) begin
            rd_reg(`PBC_OFF_DATA, v);
            `CHK("dark_bin", 32'h80000000, v)
        end
    endtask : t_free

    task automatic t_trig();
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_TRIG));
        wr_reg(`PBC_OFF_NBINS, 32'h00000001);
        wr_reg(`PBC_OFF_BLIND, 32'h00000000);
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        repeat (30) @(posedge clk);
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("armed", 3'h5, v[2:0])
        `CHK("no_bin", 13'h0000, v[28:16])
        fld.set_gate(1'b1);
        repeat (3) @(posedge clk);
        fld.burst(2, 1, 1);
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("gate_act", 1'b1, v[1])
        wait_idle();
        fld.set_gate(1'b0);
        rd_reg(`PBC_OFF_DATA, v);
        `CHK("trig_bin", 32'h80000002, v)
    endtask : t_trig

    task automatic t_gate();
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_GATE2));
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        repeat (3) @(posedge clk);
        #1;
        `CHK("apd_off", 1'b0, apd_en)
        fld.burst(2, 1, 1);
        fld.set_gate(1'b1);
        repeat (3) @(posedge clk);
        #1;
        `CHK("apd_on", 1'b1, apd_en)
        fld.burst(4, 1, 1);
        fld.set_gate(1'b0);
        wait_idle();
        rd_reg(`PBC_OFF_DATA, v);
        `CHK("gate_bin", 32'h80000004, v)
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_GATE1));
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        fld.burst(1, 1, 1);
        #1;
        `CHK("apd_low_gate", 1'b1, apd_en)
        fld.set_gate(1'b1);
        wait_idle();
        rd_reg(`PBC_OFF_DATA, v);
        `CHK("gate1_bin", 32'h80000001, v)
        fld.set_gate(1'b0);
    endtask : t_gate

    task automatic t_full();
        wr_reg(`PBC_OFF_IMASK, 32'h0000000C);
        wr_reg(`PBC_OFF_CTRL, 32'(PBC_FREE));
        wr_reg(`PBC_OFF_BIN, 32'h00000002);
        wr_reg(`PBC_OFF_GAP, 32'h00000001);
        wr_reg(`PBC_OFF_NBINS, 32'h00000000);
        wr_reg(`PBC_OFF_CMD, 32'h00000001);
        repeat (80) @(posedge clk);
        #1;
        `CHK("irq_on", 1'b1, irq)
        rd_reg(`PBC_OFF_STATUS, v);
        `CHK("overload", 1'b1, v[3])
        `CHK("lost", 1'b1, v[5])
        `CHK("lvl_full", 13'(DEPTH), v[28:16])
        wr_reg(`PBC_OFF_CMD, 32'h00000002);
        rd_reg(`PBC_OFF_ISTAT, v);
        `CHK("istat", 4'hD, v[3:0])
        for (int i = 0; i < DEPTH; i++) begin
            rd_reg(`PBC_OFF_DATA, v);
            `CHK("drain", 1'b1, v[31])
        end
        rd_reg(`PBC_OFF_DATA, v);
        `CHK("empty", 32'h00000000, v)
        wr_reg(`PBC_OFF_ISTAT, 32'h0000000F);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq_off", 1'b0, irq)
    endtask : t_full

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_manual();
        t_free();
        t_trig();
        t_gate();
        t_full();
        stop_test();
    end
endmodule : photon_bin_counter_tb
